/* shared/pcrs_pkg.sv */
// Constants for the program counter and return stack block.
// Assumes a Wishbone classic master and a core sequencer on the same clock.
package pcrs_pkg;

  localparam int PC_W = 15;
  localparam int IDX_W = 5;
  localparam int DEPTH = 16;

  // Register indices; the byte address is four times the index.
  localparam logic [11:0] IDX_STACK_INDEX = 12'hFED;
  localparam logic [11:0] IDX_TOP_LOW = 12'hFEE;
  localparam logic [11:0] IDX_TOP_HIGH = 12'hFEF;
  localparam logic [11:0] IDX_PC_LOW = 12'hFF0;
  localparam logic [11:0] IDX_PC_LATCH = 12'hFF1;
  localparam logic [11:0] IDX_CONFIG = 12'hFF2;
  localparam logic [11:0] IDX_POWER_CTRL = 12'hFF3;
  localparam logic [11:0] IDX_IRQ_MASK = 12'hFF4;

  // Field positions in the power control, mask and config registers.
  localparam int FLAG_OVF_BIT = 0;
  localparam int FLAG_UNF_BIT = 1;
  localparam int CFG_FAULT_BIT = 0;

  // Values after reset, plus the full stack index and the interrupt vector.
  localparam logic [IDX_W-1:0] STACK_INDEX_RST = 5'h1F;
  localparam logic [IDX_W-1:0] STACK_INDEX_FULL = 5'h0F;
  localparam logic [PC_W-1:0] PC_RST = 15'h0000;
  localparam logic [6:0] PC_LATCH_RST = 7'h00;
  localparam logic FAULT_EN_RST = 1'b1;
  localparam logic [1:0] FLAGS_RST = 2'h0;
  localparam logic [1:0] MASK_RST = 2'h0;
  localparam logic [PC_W-1:0] INT_VECTOR = 15'h0004;

  // Sequencer operation codes, one per cycle.
  localparam logic [3:0] OP_NONE = 4'h0;
  localparam logic [3:0] OP_NEXT = 4'h1;
  localparam logic [3:0] OP_PCL_WR = 4'h2;
  localparam logic [3:0] OP_CALL = 4'h3;
  localparam logic [3:0] OP_CALL_INDIRECT_ACC = 4'h4;
  localparam logic [3:0] OP_BRW = 4'h5;
  localparam logic [3:0] OP_BRA = 4'h6;
  localparam logic [3:0] OP_RETURN = 4'h7;
  localparam logic [3:0] OP_RETURN_WITH_LITERAL = 4'h8;
  localparam logic [3:0] OP_RETURN_FROM_INTERRUPT = 4'h9;
  localparam logic [3:0] OP_INTR = 4'hA;

endpackage : pcrs_pkg

/* logic/pcrs_core.sv */
// Program counter sequencing and return stack with a Wishbone slave.
// Assumes one operation code per clock from the core sequencer.
//
// Functional notes
// - Counter is 15 bits; low byte readable and writable, upper from latch.
// - Every reset clears the whole program counter to zero.
// - A low-byte write loads the upper seven bits from the latch together.
// - Direct call takes operand bits 10..0 and latch bits 6..3.
// - Indirect call takes accumulator as low byte, latch as upper bits.
// - Accumulator branch loads next address plus unsigned accumulator.
// - Operand branch loads next address plus signed operand, any boundary.
// - Sixteen stack entries of 15 bits, outside program and data space.
// - Calls and interrupt branch push; the three returns pop.
// - Pushes and pops leave the high latch unchanged unless they trigger a fault reset.
// - With fault reset off the stack wraps, overwriting oldest entries.
// - Overflow and underflow set their flags whether fault reset is on or not.
// - With fault reset on, overflow or underflow clears the counter and latch and sets the stack index to 1F.
// - Stack index selects the entry seen through the top entry registers.
// - Stack index is five bits so faults beyond sixteen entries show.
// - Push increments then writes; pop reads then decrements.
`timescale 1ns/100ps
module pcrs_core
  import pcrs_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [13:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic [3:0] seq_op_i,
  input wire logic [10:0] operand_i,
  input wire logic [7:0] acc_i,
  output logic [PC_W-1:0] pc_o,
  output logic fault_reset_o,
  output logic irq_o
);

  typedef struct packed {
    logic [PC_W-1:0] pc;
    logic [6:0] latch;
    logic [IDX_W-1:0] idx;
    logic [DEPTH-1:0][PC_W-1:0] stack;
    logic fault_en;
    logic [1:0] flags;
    logic [1:0] mask;
    logic ack;
    logic [7:0] dat;
    logic fault_rst;
    logic irq;
  } pcrs_state_t;

  pcrs_state_t q;
  pcrs_state_t d;

  logic push;
  logic pop;
  logic ovf;
  logic unf;
  logic [PC_W-1:0] push_val;
  logic [PC_W-1:0] inc;
  logic [IDX_W-1:0] idx_up;
  logic bus_req;
  logic bus_wr;
  logic bus_rd_done;

  function automatic logic hit(input logic [13:0] adr,
                               input logic [11:0] idx);
    hit = (adr[13:2] == idx);
  endfunction : hit

  function automatic logic [7:0] read_mux(input pcrs_state_t s,
                                          input logic [13:0] adr);
    logic [PC_W-1:0] tos;
    tos = s.stack[s.idx[3:0]];
    if (hit(adr, IDX_STACK_INDEX)) begin
      read_mux = {3'h0, s.idx};
    end else if (hit(adr, IDX_TOP_LOW)) begin
      read_mux = tos[7:0];
    end else if (hit(adr, IDX_TOP_HIGH)) begin
      read_mux = {1'b0, tos[14:8]};
    end else if (hit(adr, IDX_PC_LOW)) begin
      read_mux = s.pc[7:0];
    end else if (hit(adr, IDX_PC_LATCH)) begin
      read_mux = {1'b0, s.latch};
    end else if (hit(adr, IDX_CONFIG)) begin
      read_mux = {7'h00, s.fault_en};
    end else if (hit(adr, IDX_POWER_CTRL)) begin
      read_mux = {6'h00, s.flags};
    end else if (hit(adr, IDX_IRQ_MASK)) begin
      read_mux = {6'h00, s.mask};
    end else begin
      read_mux = 8'h00;
    end
  endfunction : read_mux

  always_comb begin
    d = q;
    push = 1'b0;
    pop = 1'b0;
    inc = q.pc + 15'h0001;
    push_val = inc;
    idx_up = q.idx + 5'h01;
    bus_req = wb_cyc_i && wb_stb_i;
    // A request is answered one cycle after it appears; writes land then.
    bus_wr = bus_req && wb_we_i && q.ack && wb_sel_i[0];
    bus_rd_done = bus_req && !wb_we_i && q.ack;
    d.ack = bus_req && !q.ack;
    d.dat = read_mux(q, wb_adr_i);
    d.fault_rst = 1'b0;

    // Bus writes first, so a core operation in the same cycle wins.
    if (bus_wr) begin
      if (hit(wb_adr_i, IDX_STACK_INDEX)) begin
        d.idx = wb_dat_i[4:0];
      end else if (hit(wb_adr_i, IDX_TOP_LOW)) begin
        d.stack[q.idx[3:0]][7:0] = wb_dat_i[7:0];
      end else if (hit(wb_adr_i, IDX_TOP_HIGH)) begin
        d.stack[q.idx[3:0]][14:8] = wb_dat_i[6:0];
      end else if (hit(wb_adr_i, IDX_PC_LOW)) begin
        d.pc = {q.latch, wb_dat_i[7:0]};
      end else if (hit(wb_adr_i, IDX_PC_LATCH)) begin
        d.latch = wb_dat_i[6:0];
      end else if (hit(wb_adr_i, IDX_CONFIG)) begin
        d.fault_en = wb_dat_i[CFG_FAULT_BIT];
      end else if (hit(wb_adr_i, IDX_IRQ_MASK)) begin
        d.mask = wb_dat_i[1:0];
      end
    end

    case (seq_op_i)
      OP_NEXT: begin
        d.pc = inc;
      end
      OP_PCL_WR: begin
        d.pc = {q.latch, operand_i[7:0]};
      end
      OP_CALL: begin
        d.pc = {q.latch[6:3], operand_i};
        push = 1'b1;
      end
      OP_CALL_INDIRECT_ACC: begin
        d.pc = {q.latch, acc_i};
        push = 1'b1;
      end
      OP_BRW: begin
        d.pc = inc + {7'h00, acc_i};
      end
      OP_BRA: begin
        d.pc = inc + {{6{operand_i[8]}}, operand_i[8:0]};
      end
      OP_RETURN, OP_RETURN_WITH_LITERAL, OP_RETURN_FROM_INTERRUPT: begin
        pop = 1'b1;
      end
      OP_INTR: begin
        d.pc = INT_VECTOR;
        push_val = q.pc;
        push = 1'b1;
      end
      default: begin
        d.pc = d.pc;
      end
    endcase

    // Stack traffic touches the latch only through a fault reset, which clears it.
    ovf = push && (q.idx == STACK_INDEX_FULL);
    unf = pop && (q.idx == STACK_INDEX_RST);
    if (push) begin
      d.idx = idx_up;
      d.stack[idx_up[3:0]] = push_val;
    end
    if (pop) begin
      d.pc = q.stack[q.idx[3:0]];
      d.idx = q.idx - 5'h01;
    end

    // Read of the flags clears them, but a fault in the same cycle wins.
    if (bus_rd_done && hit(wb_adr_i, IDX_POWER_CTRL)) begin
      d.flags = FLAGS_RST;
    end
    if (ovf) begin
      d.flags[FLAG_OVF_BIT] = 1'b1;
    end
    if (unf) begin
      d.flags[FLAG_UNF_BIT] = 1'b1;
    end
    if (q.fault_en && (ovf || unf)) begin
      d.pc = PC_RST;
      d.idx = STACK_INDEX_RST;
      d.latch = PC_LATCH_RST;
      d.fault_rst = 1'b1;
    end
    d.irq = |(d.flags & d.mask);
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      q <= '0;
      q.pc <= PC_RST;
      q.latch <= PC_LATCH_RST;
      q.idx <= STACK_INDEX_RST;
      q.fault_en <= FAULT_EN_RST;
      q.flags <= FLAGS_RST;
      q.mask <= MASK_RST;
    end else begin
      q <= d;
    end
  end

  assign pc_o = q.pc;
  assign wb_ack_o = q.ack;
  assign wb_dat_o = {24'h000000, q.dat};
  assign fault_reset_o = q.fault_rst;
  assign irq_o = q.irq;

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  logic [PC_W-1:0] tos_q;
  logic calm;
  assign tos_q = q.stack[q.idx[3:0]];
  assign calm = !(bus_req && wb_we_i);

  sequence s_call_ok;
    (seq_op_i == OP_CALL) && !(q.fault_en && q.idx == STACK_INDEX_FULL);
  endsequence

  sequence s_pop_ok;
    (seq_op_i == OP_RETURN || seq_op_i == OP_RETURN_WITH_LITERAL ||
     seq_op_i == OP_RETURN_FROM_INTERRUPT) && (q.idx != STACK_INDEX_RST);
  endsequence

  sequence s_tos_read;
    bus_req && !wb_we_i && hit(wb_adr_i, IDX_TOP_LOW) && !q.ack &&
      seq_op_i == OP_NONE;
  endsequence

  AST_RESET_PC: assert property ($fell(rst_i) |-> pc_o == 15'h0000)
    else $error("pc not cleared by reset");
  AST_PCL_LOAD: assert property ((seq_op_i == OP_PCL_WR) |=>
    pc_o == {$past(q.latch), $past(operand_i[7:0])})
    else $error("low byte write did not load latch");
  AST_CALL: assert property (s_call_ok |=>
    pc_o == {$past(q.latch[6:3]), $past(operand_i)})
    else $error("direct call target wrong");
  AST_CALL_INDIRECT_ACC: assert property ((seq_op_i == OP_CALL_INDIRECT_ACC) &&
    !(q.fault_en && q.idx == STACK_INDEX_FULL) |=>
    pc_o == {$past(q.latch), $past(acc_i)})
    else $error("indirect call target wrong");
  AST_BRW: assert property ((seq_op_i == OP_BRW) |=>
    pc_o == 15'($past(q.pc) + 15'h0001 + {7'h00, $past(acc_i)}))
    else $error("accumulator branch target wrong");
  AST_BRA: assert property ((seq_op_i == OP_BRA) |=> pc_o ==
    15'($past(q.pc) + 15'h0001 +
    {{6{$past(operand_i[8])}}, $past(operand_i[8:0])}))
    else $error("relative branch target wrong");
  AST_NEXT: assert property ((seq_op_i == OP_NEXT) |=>
    pc_o == 15'($past(q.pc) + 15'h0001))
    else $error("sequential fetch did not advance");
  AST_PUSH_POP: assert property (s_call_ok ##1 s_pop_ok |=>
    pc_o == 15'($past(q.pc, 2) + 15'h0001) && q.idx == $past(q.idx, 2))
    else $error("call then return did not restore");
  AST_LATCH_KEEP: assert property (((s_call_ok or s_pop_ok) and calm)
    |=> $stable(q.latch))
    else $error("stack traffic changed latch");
  AST_WRAP: assert property ((seq_op_i == OP_CALL) && !q.fault_en &&
    q.idx == STACK_INDEX_FULL |=> q.idx == 5'h10 &&
    q.stack[0] == 15'($past(q.pc) + 15'h0001) && !fault_reset_o)
    else $error("stack did not wrap");
  AST_FLAGS: assert property (push && q.idx == STACK_INDEX_FULL && !bus_req
    |=> q.flags[FLAG_OVF_BIT] [*2])
    else $error("overflow flag not held");
  AST_FAULT: assert property (q.fault_en && (ovf || unf) |=>
    fault_reset_o && pc_o == 15'h0000 && q.idx == 5'h1F ##1 !fault_reset_o)
    else $error("fault reset not one pulse");
  AST_TOS_READ: assert property (s_tos_read ##1 (calm && seq_op_i == OP_NONE)
    |-> wb_ack_o && wb_dat_o[7:0] == $past(tos_q[7:0]))
    else $error("top entry read wrong");
  AST_IRQ: assert property (irq_o == |(q.flags & q.mask))
    else $error("irq disagrees with flags");

  // Stack traffic, checked against the entry that each push or pop touches.
  sequence s_push_call;
    (seq_op_i == OP_CALL || seq_op_i == OP_CALL_INDIRECT_ACC) && calm &&
      !(q.fault_en && q.idx == STACK_INDEX_FULL);
  endsequence

  sequence s_push_intr;
    (seq_op_i == OP_INTR) && calm &&
      !(q.fault_en && q.idx == STACK_INDEX_FULL);
  endsequence

  // A bus write lands at the edge where the master sees ack high.
  sequence s_bus_write;
    bus_req && wb_we_i && q.ack && wb_sel_i[0] && seq_op_i == OP_NONE;
  endsequence

  AST_CALL_PUSH: assert property (s_push_call |=>
    tos_q == 15'($past(q.pc) + 15'h0001) &&
    q.idx == 5'($past(q.idx) + 5'h01))
    else $error("call did not push the return address");
  AST_INTR_PUSH: assert property (s_push_intr |=>
    pc_o == INT_VECTOR && tos_q == $past(q.pc))
    else $error("interrupt branch did not push the counter");
  AST_POP_LOAD: assert property ((s_pop_ok and calm) |=>
    pc_o == $past(tos_q) && q.idx == 5'($past(q.idx) - 5'h01))
    else $error("return did not load the top entry");
  AST_UNF_FLAG: assert property (pop && q.idx == STACK_INDEX_RST
    |=> q.flags[FLAG_UNF_BIT])
    else $error("underflow flag not set");
  AST_OVF_FAULT: assert property (push && q.fault_en &&
    q.idx == STACK_INDEX_FULL |=> q.flags[FLAG_OVF_BIT] &&
    q.latch == PC_LATCH_RST)
    else $error("overflow reset did not clear the latch");
  AST_FAULT_KEEP: assert property (q.fault_en && (ovf || unf) && calm
    |=> q.fault_en && q.mask == $past(q.mask))
    else $error("fault reset changed config or mask");
  AST_RD_CLEAR: assert property (bus_rd_done &&
    hit(wb_adr_i, IDX_POWER_CTRL) && !ovf && !unf |=> q.flags == FLAGS_RST)
    else $error("flag read did not clear");
  AST_ACK_PULSE: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held longer than one cycle");
  AST_IDX_WRITE: assert property ((s_bus_write and
    hit(wb_adr_i, IDX_STACK_INDEX)) |=> q.idx == $past(wb_dat_i[4:0]))
    else $error("stack index write lost");
  AST_TOS_WRITE: assert property ((s_bus_write and
    hit(wb_adr_i, IDX_TOP_LOW)) |=> tos_q[7:0] == $past(wb_dat_i[7:0]))
    else $error("top entry write lost");
  AST_PCL_BUS: assert property ((s_bus_write and
    hit(wb_adr_i, IDX_PC_LOW)) |=> pc_o == {$past(q.latch),
    $past(wb_dat_i[7:0])})
    else $error("low byte write did not load all bits");
  AST_HOLD: assert property ((seq_op_i == OP_NONE) && calm |=>
    $stable(pc_o))
    else $error("idle cycle moved the counter");

endmodule : pcrs_core

/* verif/pcrs_seq_model.sv */
// Core sequencer stand-in driving one operation code per clock.
// Assumes the bench calls issue only between its own bus cycles.
`timescale 1ns/100ps
module pcrs_seq_model
  import pcrs_pkg::*;
(
  input wire logic clk_i,
  output logic [3:0] seq_op_o,
  output logic [10:0] operand_o,
  output logic [7:0] acc_o
);
  initial begin
    seq_op_o = OP_NONE;
    operand_o = 11'h000;
    acc_o = 8'h00;
  end
  // One operation is held for one edge, then the code falls back to idle.
  task automatic issue(input logic [3:0] op, input logic [10:0] opd,
                       input logic [7:0] acc);
    @(posedge clk_i);
    seq_op_o <= op;
    operand_o <= opd;
    acc_o <= acc;
    @(posedge clk_i);
    seq_op_o <= OP_NONE;
    operand_o <= ~opd;
    #1;
  endtask : issue
  // Two operations on consecutive edges, such as a call and its return.
  task automatic issue_pair(input logic [3:0] op_a, input logic [10:0] opd_a,
                            input logic [3:0] op_b);
    @(posedge clk_i);
    seq_op_o <= op_a;
    operand_o <= opd_a;
    @(posedge clk_i);
    seq_op_o <= op_b;
    @(posedge clk_i);
    seq_op_o <= OP_NONE;
    #1;
  endtask : issue_pair
endmodule : pcrs_seq_model

/* verif/tb.sv */
// Self-checking bench for the program counter and return stack block.
// Assumes a Wishbone master here and the sequencer model beside it.
`timescale 1ns/100ps
module tb;
  import pcrs_pkg::*;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [13:0] adr = 14'h0000;
  logic [31:0] dat = 32'h0;
  logic [31:0] q;
  logic [31:0] wb_dat_o;
  logic wb_ack_o;
  logic [3:0] op;
  logic [10:0] opd;
  logic [7:0] acc;
  logic [PC_W-1:0] pc_o;
  logic fault_reset_o;
  logic irq_o;
  int fail_count = 0;
  int compares = 0;
  initial forever #5 clk_i = ~clk_i;
  pcrs_core i_dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF),
    .wb_dat_i(dat), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .seq_op_i(op), .operand_i(opd), .acc_i(acc), .pc_o(pc_o),
    .fault_reset_o(fault_reset_o), .irq_o(irq_o));
  pcrs_seq_model i_seq (.clk_i(clk_i), .seq_op_o(op), .operand_o(opd),
    .acc_o(acc));
  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    compares++;
    if (g !== e) begin
      fail_count++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic bus(input logic w, input logic [11:0] i, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= {i, 2'b00};
    dat <= {24'h0, d};
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 20);
    q = wb_dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
    dat <= ~dat;
    if (n >= 20) chk("ack", 32'h1, 32'h0);
  endtask : bus
  task automatic rc(input string nm, input logic [11:0] i,
                    input logic [31:0] e);
    bus(1'b0, i, 8'h00);
    chk(nm, e, q);
  endtask : rc
  task automatic t_reset_and_pcl;
    chk("pc", 32'h0, {17'h0, pc_o});
    rc("index", IDX_STACK_INDEX, 32'h1F);
    rc("unmapped", 12'h100, 32'h0);
    bus(1'b1, IDX_PC_LATCH, 8'h12);
    bus(1'b1, IDX_PC_LOW, 8'hFF);
    #1 chk("pcl", 32'h12FF, {17'h0, pc_o});
    i_seq.issue(OP_NEXT, 11'h000, 8'h00);
    chk("next", 32'h1300, {17'h0, pc_o});
  endtask : t_reset_and_pcl
  task automatic t_calls;
    bus(1'b1, IDX_PC_LATCH, 8'h7F);
    i_seq.issue(OP_CALL, 11'h123, 8'h00);
    chk("call", 32'h7923, {17'h0, pc_o});
    rc("index", IDX_STACK_INDEX, 32'h00);
    rc("toplow", IDX_TOP_LOW, 32'h01);
    rc("tophigh", IDX_TOP_HIGH, 32'h13);
    i_seq.issue(OP_INTR, 11'h000, 8'h00);
    chk("intr", 32'h0004, {17'h0, pc_o});
    i_seq.issue(OP_RETURN_FROM_INTERRUPT, 11'h000, 8'h00);
    chk("return_from_interrupt", 32'h7923, {17'h0, pc_o});
    i_seq.issue(OP_RETURN_WITH_LITERAL, 11'h000, 8'h00);
    chk("return_with_literal", 32'h1301, {17'h0, pc_o});
    rc("latch", IDX_PC_LATCH, 32'h7F);
    i_seq.issue(OP_CALL_INDIRECT_ACC, 11'h000, 8'h56);
    chk("call_indirect_acc", 32'h7F56, {17'h0, pc_o});
    i_seq.issue(OP_BRW, 11'h000, 8'hF0);
    chk("brw", 32'h0047, {17'h0, pc_o});
    i_seq.issue(OP_BRA, 11'h1FE, 8'h00);
    chk("bra", 32'h0046, {17'h0, pc_o});
    i_seq.issue(OP_RETURN, 11'h000, 8'h00);
    chk("ret", 32'h1302, {17'h0, pc_o});
    i_seq.issue(OP_PCL_WR, 11'h034, 8'h00);
    chk("pclop", 32'h7F34, {17'h0, pc_o});
    i_seq.issue_pair(OP_CALL, 11'h000, OP_RETURN);
    chk("callret", 32'h7F35, {17'h0, pc_o});
  endtask : t_calls
  task automatic t_underflow;
    bus(1'b1, IDX_IRQ_MASK, 8'h02);
    i_seq.issue(OP_RETURN, 11'h000, 8'h00);
    chk("fault", 32'h1, {31'h0, fault_reset_o});
    chk("pc", 32'h0, {17'h0, pc_o});
    rc("index", IDX_STACK_INDEX, 32'h1F);
    chk("irq", 32'h1, {31'h0, irq_o});
    rc("flags", IDX_POWER_CTRL, 32'h02);
    rc("flags", IDX_POWER_CTRL, 32'h00);
    chk("irq", 32'h0, {31'h0, irq_o});
  endtask : t_underflow
  task automatic t_wrap;
    bus(1'b1, IDX_CONFIG, 8'h00);
    for (int k = 0; k < 17; k++) begin
      i_seq.issue(OP_CALL, k[10:0], 8'h00);
      chk("nofault", 32'h0, {31'h0, fault_reset_o});
    end
    rc("index", IDX_STACK_INDEX, 32'h10);
    rc("toplow", IDX_TOP_LOW, 32'h10);
    rc("flags", IDX_POWER_CTRL, 32'h01);
    bus(1'b1, IDX_TOP_LOW, 8'hAA);
    rc("toplow", IDX_TOP_LOW, 32'hAA);
    bus(1'b1, IDX_STACK_INDEX, 8'h01);
    rc("entry1", IDX_TOP_LOW, 32'h01);
  endtask : t_wrap
  task automatic t_overflow_and_reset;
    bus(1'b1, IDX_CONFIG, 8'h01);
    bus(1'b1, IDX_STACK_INDEX, 8'h0F);
    i_seq.issue(OP_CALL, 11'h001, 8'h00);
    chk("ovffault", 32'h1, {31'h0, fault_reset_o});
    rc("flags", IDX_POWER_CTRL, 32'h01);
    bus(1'b1, IDX_CONFIG, 8'h00);
    i_seq.issue(OP_NEXT, 11'h000, 8'h00);
    chk("next", 32'h0001, {17'h0, pc_o});
    @(posedge clk_i);
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    chk("pc", 32'h0, {17'h0, pc_o});
    rc("config", IDX_CONFIG, 32'h01);
    rc("index", IDX_STACK_INDEX, 32'h1F);
  endtask : t_overflow_and_reset
  task automatic tally_and_finish;
    $display("compares %0d mismatches %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : tally_and_finish
  initial begin
    #100000;
    fail_count++;
    tally_and_finish();
  end
  initial begin
    repeat (10) @(posedge clk_i);
    rst_i <= 1'b0;
    t_reset_and_pcl();
    t_calls();
    t_underflow();
    t_wrap();
    t_overflow_and_reset();
    tally_and_finish();
  end
endmodule : tb
